/* rtl/sfep_core.sv */
// serial flash erase and program sequencer with its array, device side
`timescale 1ns/100ps
`include "sfep_params.svh"
module sfep_core #(
  parameter int ADDR_W              = 20,
  parameter int SECTOR_ERASE_CYCLES = `SFEP_SECTOR_ERASE_TIME_NS / `SFEP_CLK_PERIOD_NS,
  parameter int HALF_ERASE_CYCLES   = `SFEP_HALF_BLOCK_ERASE_TIME_NS / `SFEP_CLK_PERIOD_NS,
  parameter int BLOCK_ERASE_CYCLES  = `SFEP_BLOCK_ERASE_TIME_NS / `SFEP_CLK_PERIOD_NS,
  parameter int CHIP_ERASE_CYCLES   = `SFEP_CHIP_ERASE_TIME_NS / `SFEP_CLK_PERIOD_NS,
  parameter int PAGE_WRITE_CYCLES   = `SFEP_PAGE_WRITE_TIME_NS / `SFEP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  // serial link from the host
  input  wire sfep_pkg::sfep_link_t i_link,
  output logic [3:0]                o_sio,
  output logic [3:0]                o_sio_oe_n,
  // protection setting and status
  input  wire logic [4:0]           i_protect_bits,
  output logic                      o_write_latch_flag,
  output logic                      o_op_in_progress,
  // array inspection port
  input  wire logic [ADDR_W-1:0]    i_rd_addr,
  output logic [7:0]                o_rd_data
);
  localparam logic [31:0] MEM_BYTES = 32'h1 << ADDR_W;
  localparam logic [31:0] ADDR_MASK = MEM_BYTES - 32'h1;

  sfep_pkg::sfep_link_t  s1, s2, s3, lvl, next_lvl;
  sfep_pkg::sfep_state_t state, next_state;
  sfep_pkg::sfep_opk_t   op, next_op;
  logic [5:0]        head_cnt, next_head;
  logic [31:0]       sh, next_sh;
  logic [7:0]        opc, next_opc;
  logic [7:0]        byte_sh, next_byte_sh;
  logic [2:0]        dbit, next_dbit;
  logic [7:0]        col, next_col;
  logic [255:0]      mask, next_mask;
  logic              got_data, next_got;
  logic              latch, next_latch;
  logic              busy, next_busy;
  logic              walk_on, next_walk_on;
  logic [ADDR_W-1:0] walk_addr, next_walk_addr;
  logic [ADDR_W-1:0] walk_end, next_walk_end;
  logic [31:0]       timer, next_timer;
  logic              sclk_rise, cs_fall, cs_rise;
  logic              is_erase, is_chip, is_prog, is_dual;
  logic [23:0]       emask;
  logic [31:0]       rlo, rhi, ecycles;
  logic              hit;
  logic              buf_we, arr_we;
  logic [7:0]        arr_wdata;
  logic [7:0]        pbuf [0:255];
  logic [7:0]        mem [0:MEM_BYTES-1];

  function automatic logic prot_hit(input logic [31:0] lo, input logic [31:0] hi,
                                    input logic [4:0] bp);
    logic [31:0] size;
    logic [31:0] plo;
    logic [31:0] phi;
    size = (bp[4] ? `SFEP_SECTOR_BYTES : `SFEP_BLOCK_BYTES) << (bp[2:0] - 3'h1);
    if (bp[2:0] == 3'h7 || size > MEM_BYTES) begin
      size = MEM_BYTES;
    end
    plo = bp[3] ? 32'h0 : MEM_BYTES - size;
    phi = bp[3] ? size - 32'h1 : ADDR_MASK;
    prot_hit = (bp[2:0] != 3'h0) && (lo <= phi) && (hi >= plo);
  endfunction

  // link levels settle once the second and third stages agree
  always_comb begin
    next_lvl  = sfep_pkg::sfep_link_t'((~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl));
    sclk_rise = next_lvl.sclk & ~lvl.sclk;
    cs_fall   = ~next_lvl.cs_n & lvl.cs_n;
    cs_rise   = next_lvl.cs_n & ~lvl.cs_n;
  end

  // opcode decode and target region
  always_comb begin
    is_erase = (opc == `SFEP_OP_SECTOR_ERASE) || (opc == `SFEP_OP_HALF_BLOCK_ERASE) ||
               (opc == `SFEP_OP_BLOCK_ERASE);
    is_chip  = (opc == `SFEP_OP_CHIP_ERASE_A) || (opc == `SFEP_OP_CHIP_ERASE_B);
    is_prog  = (opc == `SFEP_OP_PAGE_WRITE) || (opc == `SFEP_OP_DUAL_PAGE_WRITE);
    is_dual  = (opc == `SFEP_OP_DUAL_PAGE_WRITE);
    case (opc)
      `SFEP_OP_SECTOR_ERASE: begin
        emask   = `SFEP_SECTOR_MASK;
        ecycles = 32'(SECTOR_ERASE_CYCLES);
      end
      `SFEP_OP_HALF_BLOCK_ERASE: begin
        emask   = `SFEP_HALF_BLOCK_MASK;
        ecycles = 32'(HALF_ERASE_CYCLES);
      end
      `SFEP_OP_BLOCK_ERASE: begin
        emask   = `SFEP_BLOCK_MASK;
        ecycles = 32'(BLOCK_ERASE_CYCLES);
      end
      `SFEP_OP_PAGE_WRITE, `SFEP_OP_DUAL_PAGE_WRITE: begin
        emask   = `SFEP_PAGE_MASK;
        ecycles = 32'(PAGE_WRITE_CYCLES);
      end
      default: begin
        emask   = 24'hffffff;
        ecycles = 32'(CHIP_ERASE_CYCLES);
      end
    endcase
    rlo = is_chip ? 32'h0 : (32'(sh[23:0]) & ~32'(emask)) & ADDR_MASK;
    rhi = is_chip ? ADDR_MASK : (32'(sh[23:0]) | 32'(emask)) & ADDR_MASK;
    hit = is_chip ? (i_protect_bits != 5'h00)
                  : prot_hit(rlo, rhi, i_protect_bits);
  end

  // frame decoding and the self-timed cycle
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_head      = head_cnt;
    next_sh        = sh;
    next_opc       = opc;
    next_byte_sh   = byte_sh;
    next_dbit      = dbit;
    next_col       = col;
    next_mask      = mask;
    next_got       = got_data;
    next_latch     = latch;
    next_busy      = busy;
    next_walk_on   = walk_on;
    next_walk_addr = walk_addr;
    next_walk_end  = walk_end;
    next_timer     = timer;
    buf_we         = 1'b0;
    if (cs_fall) begin
      next_state = busy ? sfep_pkg::SFEP_ST_SKIP : sfep_pkg::SFEP_ST_HEAD;
      next_head  = 6'h00;
      next_dbit  = 3'h0;
      next_got   = 1'b0;
      next_mask  = '0;
    end else if (cs_rise) begin
      next_state = sfep_pkg::SFEP_ST_IDLE;
      if (state == sfep_pkg::SFEP_ST_HEAD && head_cnt == `SFEP_OPCODE_BITS &&
          opc == `SFEP_OP_WRITE_ENABLE) begin
        next_latch = 1'b1;
      end
      if (latch && ((state == sfep_pkg::SFEP_ST_HEAD &&
                     ((head_cnt == `SFEP_OPCODE_BITS && is_chip) ||
                      (head_cnt == `SFEP_HEAD_BITS && is_erase))) ||
                    (state == sfep_pkg::SFEP_ST_DATA && dbit == 3'h0 &&
                     got_data))) begin
        if (hit) begin
          next_latch = 1'b0;
        end else begin
          next_busy      = 1'b1;
          next_op        = is_prog ? sfep_pkg::SFEP_OPK_PROGRAM : sfep_pkg::SFEP_OPK_ERASE;
          next_walk_on   = 1'b1;
          next_walk_addr = rlo[ADDR_W-1:0];
          next_walk_end  = rhi[ADDR_W-1:0];
          next_timer     = ecycles - 32'h1;
        end
      end
    end else if (sclk_rise) begin
      case (state)
        sfep_pkg::SFEP_ST_HEAD: begin
          if (head_cnt == `SFEP_HEAD_BITS ||
              (head_cnt == `SFEP_OPCODE_BITS && !is_erase && !is_prog)) begin
            next_state = sfep_pkg::SFEP_ST_SKIP;
          end else begin
            next_head = head_cnt + 6'h01;
            next_sh   = {sh[30:0], next_lvl.sio[0]};
            if (next_head == `SFEP_OPCODE_BITS) begin
              next_opc = next_sh[7:0];
            end
            if (next_head == `SFEP_HEAD_BITS && is_prog) begin
              next_state = sfep_pkg::SFEP_ST_DATA;
              next_col   = next_sh[7:0];
            end
          end
        end
        sfep_pkg::SFEP_ST_DATA: begin
          if (is_dual) begin
            next_byte_sh = {byte_sh[5:0], next_lvl.sio[1:0]};
            next_dbit    = dbit + 3'h2;
          end else begin
            next_byte_sh = {byte_sh[6:0], next_lvl.sio[0]};
            next_dbit    = dbit + 3'h1;
          end
          if (next_dbit == 3'h0) begin
            buf_we          = 1'b1;
            next_mask[col]  = 1'b1;
            next_col        = col + 8'h01;
            next_got        = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (busy) begin
      if (timer != 32'h0) begin
        next_timer = timer - 32'h1;
      end
      if (walk_on) begin
        next_walk_addr = walk_addr + ADDR_W'(1);
        next_walk_on   = (walk_addr != walk_end);
      end
      if (timer == 32'h0 && !walk_on) begin
        next_busy  = 1'b0;
        next_latch = 1'b0;
        next_op    = sfep_pkg::SFEP_OPK_NONE;
      end
    end
  end

  // array update as the walker passes each byte of an erase, or each byte the page buffer marked in a program
  always_comb begin
    arr_we    = busy && walk_on &&
                (op == sfep_pkg::SFEP_OPK_ERASE || mask[walk_addr[7:0]]);
    arr_wdata = (op == sfep_pkg::SFEP_OPK_ERASE) ? `SFEP_ERASED_BYTE
                : mem[walk_addr] & pbuf[walk_addr[7:0]];
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1        <= '1;
      s2        <= '1;
      s3        <= '1;
      lvl       <= '1;
      state     <= sfep_pkg::SFEP_ST_IDLE;
      op        <= sfep_pkg::SFEP_OPK_NONE;
      head_cnt  <= 6'h00;
      sh        <= 32'h0;
      opc       <= 8'h00;
      byte_sh   <= 8'h00;
      dbit      <= 3'h0;
      col       <= 8'h00;
      mask      <= '0;
      got_data  <= 1'b0;
      latch     <= 1'b0;
      busy      <= 1'b0;
      walk_on   <= 1'b0;
      walk_addr <= '0;
      walk_end  <= '0;
      timer     <= 32'h0;
    end else begin
      s1        <= i_link;
      s2        <= s1;
      s3        <= s2;
      lvl       <= next_lvl;
      state     <= next_state;
      op        <= next_op;
      head_cnt  <= next_head;
      sh        <= next_sh;
      opc       <= next_opc;
      byte_sh   <= next_byte_sh;
      dbit      <= next_dbit;
      col       <= next_col;
      mask      <= next_mask;
      got_data  <= next_got;
      latch     <= next_latch;
      busy      <= next_busy;
      walk_on   <= next_walk_on;
      walk_addr <= next_walk_addr;
      walk_end  <= next_walk_end;
      timer     <= next_timer;
    end
  end

  // page buffer and array; a busy cycle never overlaps frame capture
  always_ff @(posedge i_clk) begin
    if (buf_we) begin
      pbuf[col] <= next_byte_sh;
    end
    if (arr_we) begin
      mem[walk_addr] <= arr_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_write_latch_flag <= 1'b0;
      o_op_in_progress   <= 1'b0;
      o_rd_data          <= 8'h00;
      o_sio              <= 4'h0;
      o_sio_oe_n         <= 4'hf;
    end else begin
      o_write_latch_flag <= next_latch;
      o_op_in_progress   <= next_busy;
      o_rd_data          <= mem[i_rd_addr];
      o_sio              <= 4'h0;
      o_sio_oe_n         <= 4'hf;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_start_needs_latch: assert property ($rose(busy) |-> latch)
    else $error("busy cycle began without write latch");
  a_done_clears_latch: assert property ($fell(busy) |->
                                        !latch && !o_op_in_progress ##1 !o_write_latch_flag)
    else $error("latch not cleared at end of cycle");
  a_start_on_release: assert property ($rose(busy) |->
                                       $past(cs_rise) && o_op_in_progress)
    else $error("busy cycle began without chip select rise");
  a_erase_boundary: assert property ($rose(busy) && !is_chip &&
                                     op == sfep_pkg::SFEP_OPK_ERASE
                                     |-> $past(head_cnt) == `SFEP_HEAD_BITS)
    else $error("erase started off the byte boundary");
  a_chip_unprotected: assert property ($rose(busy) && is_chip
                                       |-> $past(i_protect_bits) == 5'h00)
    else $error("chip erase started while protected");
  a_prog_boundary: assert property ($rose(busy) && op == sfep_pkg::SFEP_OPK_PROGRAM
                                    |-> $past(dbit) == 3'h0 && $past(got_data))
    else $error("program started off a data byte boundary");
  a_erase_ones: assert property (arr_we && op == sfep_pkg::SFEP_OPK_ERASE
                                 |=> mem[$past(walk_addr)] == `SFEP_ERASED_BYTE)
    else $error("erase left a byte other than all ones");
  a_page_wrap: assert property (busy && walk_on && op == sfep_pkg::SFEP_OPK_PROGRAM
                                |=> $stable(walk_addr[ADDR_W-1:8]) || !walk_on)
    else $error("program walker left its page");
  a_protect_skip: assert property ($rose(busy) |-> !$past(hit))
    else $error("protected region was started");
  a_protect_latch: assert property (cs_rise && latch && hit && is_erase &&
                                    state == sfep_pkg::SFEP_ST_HEAD &&
                                    head_cnt == `SFEP_HEAD_BITS |=> !latch && !busy)
    else $error("protected erase kept latch or started");

  c_sector_erase: cover property ($rose(busy) && opc == `SFEP_OP_SECTOR_ERASE);
  c_page_write: cover property ($rose(busy) && opc == `SFEP_OP_PAGE_WRITE);
  c_dual_write: cover property ($rose(busy) && is_dual);
  c_chip_erase: cover property ($rose(busy) && is_chip);
endmodule

/* rtl/sfep_params.svh */
// constants of the serial flash erase and program sequencer
`ifndef SFEP_PARAMS_SVH
`define SFEP_PARAMS_SVH
// opcodes
`define SFEP_OP_WRITE_ENABLE     8'h06
`define SFEP_OP_SECTOR_ERASE     8'h20
`define SFEP_OP_HALF_BLOCK_ERASE 8'h52
`define SFEP_OP_BLOCK_ERASE      8'hd8
`define SFEP_OP_CHIP_ERASE_A     8'h60
`define SFEP_OP_CHIP_ERASE_B     8'hc7
`define SFEP_OP_PAGE_WRITE       8'h02
`define SFEP_OP_DUAL_PAGE_WRITE  8'ha2
// frame bit counts
`define SFEP_OPCODE_BITS         6'h08
`define SFEP_HEAD_BITS           6'h20
// region masks and sizes
`define SFEP_SECTOR_MASK         24'h000fff
`define SFEP_HALF_BLOCK_MASK     24'h007fff
`define SFEP_BLOCK_MASK          24'h00ffff
`define SFEP_PAGE_MASK           24'h0000ff
`define SFEP_SECTOR_BYTES        32'h00001000
`define SFEP_BLOCK_BYTES         32'h00010000
`define SFEP_ERASED_BYTE         8'hff
// self-timed cycle durations
`define SFEP_CLK_PERIOD_NS       40
`define SFEP_SECTOR_ERASE_TIME_NS     400000
`define SFEP_HALF_BLOCK_ERASE_TIME_NS 1600000
`define SFEP_BLOCK_ERASE_TIME_NS      3200000
`define SFEP_CHIP_ERASE_TIME_NS       8000000
`define SFEP_PAGE_WRITE_TIME_NS       800000
`endif

/* rtl/sfep_pkg.sv */
// types of the serial flash erase and program sequencer
package sfep_pkg;
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] sio;
  } sfep_link_t;
  typedef enum logic [1:0] {
    SFEP_ST_IDLE = 2'b00,
    SFEP_ST_HEAD = 2'b01,
    SFEP_ST_DATA = 2'b10,
    SFEP_ST_SKIP = 2'b11
  } sfep_state_t;
  typedef enum logic [1:0] {
    SFEP_OPK_NONE    = 2'b00,
    SFEP_OPK_ERASE   = 2'b01,
    SFEP_OPK_PROGRAM = 2'b10
  } sfep_opk_t;
endpackage

/* testbench/sfep_host.sv */
// host side serial controller model that drives the link of the sequencer
`timescale 1ns/100ps
module sfep_host (
  // clock
  input  wire logic            i_clk,
  // link to the device
  output sfep_pkg::sfep_link_t o_link
);
  logic [2:0] upper_pattern = 3'h0;
  logic       sel_n         = 1'b1;
  logic       sck           = 1'b0;
  logic       d0            = 1'b0;
  logic       d1            = 1'b0;
  logic       dual_on       = 1'b0;

  // unused lines toggle every one, two and four cycles so no stale level can pass for data
  always @(negedge i_clk) upper_pattern <= upper_pattern + 3'h1;

  assign o_link = '{cs_n: sel_n, sclk: sck,
                    sio: {upper_pattern[2:1], dual_on ? d1 : upper_pattern[0], d0}};

  task automatic pause(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // one link clock of 320 ns, data set while the clock is low
  task automatic shift(input logic b1, input logic b0);
    d1 = b1;
    d0 = b0;
    pause(4);
    sck = 1'b1;
    pause(4);
    sck = 1'b0;
  endtask

  // bytes from index dual_from on go two bits a clock; extra adds stray bits
  task automatic frame(input logic [7:0] bytes[$], input int dual_from, input int extra);
    int i;
    int k;
    sel_n = 1'b0;
    pause(4);
    for (i = 0; i < bytes.size(); i++) begin
      dual_on = (i >= dual_from);
      if (dual_on) begin
        for (k = 7; k > 0; k -= 2) shift(bytes[i][k], bytes[i][k-1]);
      end else begin
        for (k = 7; k >= 0; k--) shift(d1, bytes[i][k]);
      end
    end
    for (k = 0; k < extra; k++) shift(d1, 1'b1);
    pause(4);
    sel_n = 1'b1;
    dual_on = 1'b0;
    d0 = ~d0;
    d1 = ~d1;
    pause(8);
  endtask
endmodule

/* testbench/sfep_core_tb.sv */
// self-checking bench of the erase and program sequencer
`timescale 1ns/100ps
module sfep_core_tb;
  logic                 clk;
  logic                 reset_n;
  sfep_pkg::sfep_link_t link;
  logic [3:0]           sio;
  logic [3:0]           sio_oe_n;
  logic [4:0]           protect_bits;
  logic                 latch;
  logic                 busy;
  logic [15:0]          rd_addr;
  logic [7:0]           rd_data;
  int                   errors;
  int                   checked;
  logic [7:0]           pop[4];
  logic [15:0]          padr[4];
  logic [7:0]           q[$];

  sfep_host host (.i_clk(clk), .o_link(link));

  // 32K and 64K erases only meet protection here, so their durations keep defaults
  sfep_core #(.ADDR_W(16), .SECTOR_ERASE_CYCLES(1), .CHIP_ERASE_CYCLES(1),
    .PAGE_WRITE_CYCLES(1)) dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_link(link), .o_sio(sio), .o_sio_oe_n(sio_oe_n),
    .i_protect_bits(protect_bits), .o_write_latch_flag(latch), .o_op_in_progress(busy),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check1(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic status(input logic exp_busy, input logic exp_latch);
    check1("busy", exp_busy, busy);
    check1("latch", exp_latch, latch);
  endtask

  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    rd_addr = addr;
    repeat (2) @(negedge clk);
    check8("array byte", exp, rd_data);
  endtask

  task automatic write_enable_cmd;
    host.frame({8'h06}, 99, 0);
    check1("latch", 1'b1, latch);
  endtask

  task automatic wait_idle(input int limit);
    int n;
    for (n = 0; n < limit && busy !== 1'b0; n++) @(negedge clk);
    check1("busy", 1'b0, busy);
    check1("latch", 1'b0, latch);
  endtask

  task automatic end_sim;
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(negedge clk);
    errors++;
    end_sim;
  end

  initial begin
    errors = 0;
    checked = 0;
    reset_n = 1'b0;
    protect_bits = 5'h00;
    rd_addr = 16'h0000;
    pop = '{8'h20, 8'h52, 8'hd8, 8'h02};
    padr = '{16'hf123, 16'h8000, 16'h0000, 16'hf000};
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    status(1'b0, 1'b0);
    host.frame({8'hc7}, 99, 0);
    status(1'b0, 1'b0);
    write_enable_cmd();
    protect_bits = 5'h01;
    host.frame({8'h60}, 99, 0);
    status(1'b0, 1'b0);
    protect_bits = 5'h00;
    write_enable_cmd();
    host.frame({8'hc7}, 99, 0);
    status(1'b1, 1'b1);
    check8("line enable", 8'h0f, {4'h0, sio_oe_n});
    check8("line drive", 8'h00, {4'h0, sio});
    wait_idle(70000);
    rd(16'h0000, 8'hff);
    rd(16'hffff, 8'hff);
    write_enable_cmd();
    host.frame({8'h02, 8'h00, 8'h01, 8'hfe, 8'ha5, 8'h3c, 8'h0f}, 99, 0);
    check1("busy", 1'b1, busy);
    wait_idle(2000);
    rd(16'h01fe, 8'ha5);
    rd(16'h01ff, 8'h3c);
    rd(16'h0100, 8'h0f);
    rd(16'h0200, 8'hff);
    write_enable_cmd();
    host.frame({8'ha2, 8'h00, 8'h01, 8'hfe, 8'hf0, 8'hf0}, 4, 0);
    wait_idle(2000);
    rd(16'h01fe, 8'ha0);
    rd(16'h01ff, 8'h30);
    write_enable_cmd();
    host.frame({8'h02, 8'h00, 8'h03, 8'h00, 8'h55}, 99, 4);
    status(1'b0, 1'b1);
    host.frame({8'h20, 8'h00, 8'h01, 8'h05}, 99, 1);
    status(1'b0, 1'b1);
    rd(16'h0300, 8'hff);
    host.frame({8'h20, 8'h00, 8'h01, 8'h05}, 99, 0);
    status(1'b1, 1'b1);
    wait_idle(6000);
    rd(16'h01fe, 8'hff);
    rd(16'h0100, 8'hff);
    protect_bits = 5'h11;
    for (int i = 0; i < 4; i++) begin
      write_enable_cmd();
      q = {pop[i], 8'h00, padr[i][15:8], padr[i][7:0]};
      if (pop[i] == 8'h02) begin
        q.push_back(8'h00);
      end
      host.frame(q, 99, 0);
      status(1'b0, 1'b0);
    end
    rd(16'hf000, 8'hff);
    rd(16'hf123, 8'hff);
    end_sim;
  end
endmodule
